//--- verif/tmc_core_tb.sv
/*
 self-checking testbench of the core: runs short programs and judges
 the port traffic logged by the far-side model.
 assumes the model's rom and log are reachable by hierarchy.
*/
`timescale 1ns/1ps
module tmc_core_tb;
    logic             i_mclk;
    logic             i_resetn;
    logic             i_interrupt;
    logic [7:0]       addr;
    logic [15:0]      instr;
    logic [7:0]       in_port;
    tmc_pkg::tmc_io_t io;
    int               err_total;
    int               checks;

    initial i_mclk = 1'b0;
    always #5 i_mclk = ~i_mclk;

    tmc_core u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .o_addr(addr), .i_instr(instr),
                    .i_in_port(in_port), .i_interrupt(i_interrupt), .o_io(io));

    tmc_user_model u_mem (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(addr),
                          .o_instr(instr), .i_io(io), .o_in_port(in_port));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // unused words jump to themselves so a stray pc parks quietly
    task automatic load(input logic [15:0] p[$]);
        for (int i = 0; i < 256; i++)
            u_mem.rom[i] = {8'he0, 8'(i)};
        foreach (p[i])
            u_mem.rom[i] = p[i];
    endtask

    task automatic put(input logic [7:0] a, input logic [15:0] w);
        u_mem.rom[a] = w;
    endtask

    task automatic go(input int n);
        @(negedge i_mclk);
        i_resetn = 1'b0;
        repeat (2) @(negedge i_mclk);
        check("rst_addr", 16'(addr), 16'(tmc_pkg::RST_PC));
        check("rst_strobes", {io.rd, io.wr}, 16'h0000);
        i_resetn = 1'b1;
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic chk_wr(input int k, input logic [7:0] ps, input logic [7:0] d);
        check("wr_psel", 16'(u_mem.wr_psel[k]), 16'(ps));
        check("wr_data", 16'(u_mem.wr_data[k]), 16'(d));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic sc_alu;
        load('{16'h00ff, 16'h4001, 16'h0110, 16'h5100, 16'hc001, 16'hc102, 16'h0205,
               16'h6206, 16'h0303, 16'h7301, 16'h8211, 16'hc203, 16'hc304});
        go(40);
        check("alu_nwr", 16'(u_mem.n_wr), 16'h0004);
        chk_wr(0, 8'h01, 8'h00);
        chk_wr(1, 8'h02, 8'h11);
        chk_wr(2, 8'h03, 8'h11);
        chk_wr(3, 8'h04, 8'h01);
    endtask

    task automatic sc_io;
        load('{16'ha1c5, 16'hc1f0, 16'h02a0, 16'hb320, 16'hd320});
        go(30);
        check("io_nrd", 16'(u_mem.n_rd), 16'h0002);
        check("io_rd_cyc", 16'(u_mem.first_rd), 16'h0002);
        check("io_wr_cyc", 16'(u_mem.first_wr), 16'h0004);
        chk_wr(0, 8'hf0, 8'h9f);
        chk_wr(1, 8'ha0, 8'hfa);
        check("io_psel", 16'(io.psel), 16'h00a0);
        check("io_data", 16'(io.data), 16'h00fa);
        check("io_wr_idle", 16'(io.wr), 16'h0000);
    endtask

    // shifts, or/xor and conditional return; a wrong return leaves 77 or ff in s1
    task automatic sc_shift;
        load('{16'h0081, 16'h9002, 16'hc001, 16'h9009, 16'hc002, 16'hf010, 16'hc103});
        put(8'h10, 16'h013c);
        put(8'h11, 16'h21c3);
        put(8'h12, 16'h9014);
        put(8'h13, 16'h31ff);
        put(8'h14, 16'h9014);
        put(8'h15, 16'h0177);
        put(8'h16, 16'h9010);
        go(50);
        check("sh_nwr", 16'(u_mem.n_wr), 16'h0003);
        chk_wr(0, 8'h01, 8'hc0);
        chk_wr(1, 8'h02, 8'h81);
        chk_wr(2, 8'h03, 8'h00);
    endtask

    // fifteen nested calls, the deepest the stack guarantees
    task automatic sc_stack;
        load('{16'h0000, 16'hf010, 16'hc0aa});
        put(8'h10, 16'h4001);
        put(8'h11, 16'h8100);
        put(8'h12, 16'h610f);
        put(8'h13, 16'hf610);
        put(8'h14, 16'h9010);
        go(300);
        check("stk_nwr", 16'(u_mem.n_wr), 16'h0001);
        chk_wr(0, 8'haa, 8'h0f);
    endtask

    task automatic sc_flow;
        load('{16'h0000, 16'he503, 16'hc0ee, 16'h4000, 16'he406, 16'hc0ee, 16'he6ee,
               16'hf020, 16'hc109, 16'hc30d});
        put(8'h20, 16'h0177);
        put(8'h21, 16'h9010);
        go(60);
        check("flow_nwr", 16'(u_mem.n_wr), 16'h0002);
        chk_wr(0, 8'h09, 8'h77);
        chk_wr(1, 8'h0d, 8'hfa);
    endtask

    task automatic sc_irq;
        load('{16'h0000, 16'hc011, 16'h4000, 16'h9031, 16'he404, 16'hc0ee});
        put(tmc_pkg::IRQ_VEC, 16'he040);
        put(8'h40, 16'h0155);
        put(8'h41, 16'h4101);
        put(8'h42, 16'hc150);
        put(8'h43, 16'h0200);
        put(8'h44, 16'h9021);
        i_interrupt = 1'b1;
        go(0);
        for (int i = 0; i < 200 && u_mem.n_wr < 2; i++)
            @(negedge i_mclk);
        if (u_mem.n_wr != 2)
        begin
            check("irq_wait", 16'(u_mem.n_wr), 16'h0002);
            end_sim();
        end
        i_interrupt = 1'b0;
        repeat (30) @(negedge i_mclk);
        check("irq_nwr1", 16'(u_mem.n_wr), 16'h0002);
        chk_wr(0, 8'h11, 8'h00);
        chk_wr(1, 8'h50, 8'h56);
        i_interrupt = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_interrupt = 1'b0;
        repeat (40) @(negedge i_mclk);
        check("irq_nwr2", 16'(u_mem.n_wr), 16'h0003);
        chk_wr(2, 8'h50, 8'h56);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        err_total = 0;
        checks = 0;
        i_resetn = 1'b0;
        i_interrupt = 1'b0;
        repeat (4) @(negedge i_mclk);
        sc_alu();
        sc_io();
        sc_shift();
        sc_stack();
        sc_flow();
        sc_irq();
        end_sim();
    end
endmodule

//--- verif/tmc_user_model.sv
/*
 far-side model of the core: program memory with one-cycle synchronous
 read and input/output port logic with a write log.
 assumes the testbench fills rom by hierarchical reference.
*/
`timescale 1ns/1ps
module tmc_user_model
(
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_addr,
    output logic [15:0]      o_instr,
    input  tmc_pkg::tmc_io_t i_io,
    output logic [7:0]       o_in_port
);
    logic [15:0] rom [256];
    logic [7:0]  wr_psel [16];
    logic [7:0]  wr_data [16];
    int          n_wr;
    int          n_rd;
    int          cyc;
    int          first_rd;
    int          first_wr;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_mclk)
    begin
        o_instr <= rom[i_addr];
    end

    // data is only valid while the read is pulsed; otherwise show garbage
    assign o_in_port = i_io.rd ? (i_io.psel ^ 8'h5a) : ~(i_io.psel ^ 8'h5a);

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            n_wr = 0;
            n_rd = 0;
            cyc = 0;
            first_rd = -1;
            first_wr = -1;
        end
        else
        begin
            if (i_io.rd)
            begin
                if (n_rd == 0)
                    first_rd = cyc;
                n_rd = n_rd + 1;
            end
            if (i_io.wr && n_wr < 16)
            begin
                wr_psel[n_wr] = i_io.psel;
                wr_data[n_wr] = i_io.data;
                if (n_wr == 0)
                    first_wr = cyc;
                n_wr = n_wr + 1;
            end
            cyc = cyc + 1;
        end
    end
endmodule

//--- verilog/tmc_core.sv
/*
 8-bit core: fetch/execute in two cycles, call stack, interrupt and
 port strobes. assumes a program memory with one-cycle synchronous read
 on i_mclk and port logic on the same clock.
*/
`timescale 1ns/1ps
module tmc_core
#(
    parameter int unsigned STK_DEPTH = tmc_pkg::STK_MAX
)
(
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    output logic [7:0]        o_addr,
    input  wire logic [15:0]  i_instr,
    input  wire logic [7:0]   i_in_port,
    input  wire logic         i_interrupt,
    output tmc_pkg::tmc_io_t  o_io
);

    if (STK_DEPTH < 2 || STK_DEPTH > tmc_pkg::STK_MAX)
    begin : g_chk
        $error("STK_DEPTH out of range");
    end

    localparam logic [3:0] SP_LAST = 4'(STK_DEPTH - 1);

    tmc_pkg::tmc_state_t s_ff;
    tmc_pkg::tmc_state_t nxt_s;
    tmc_pkg::tmc_wr_t    rb_wr;
    tmc_pkg::tmc_alu_t   res;

    logic [3:0] op;
    logic [3:0] sx;
    logic [3:0] sy;
    logic [7:0] kk;
    logic [7:0] rx;
    logic [7:0] ry;
    logic       irq;
    logic [3:0] sp_dn;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic cond_ok(input logic [3:0] cc, input logic z,
                                     input logic c);
        logic ok;
        ok = 1'b0;
        case (cc)
            tmc_pkg::C_ALW: ok = 1'b1;
            tmc_pkg::C_Z:   ok = z;
            tmc_pkg::C_NZ:  ok = ~z;
            tmc_pkg::C_C:   ok = c;
            tmc_pkg::C_NC:  ok = ~c;
            default:        ok = 1'b0;
        endcase
        return ok;
    endfunction

    // carry of SUB is the borrow
    function automatic tmc_pkg::tmc_alu_t alu(input logic [2:0] f,
        input logic [7:0] a, input logic [7:0] b, input logic cin);
        tmc_pkg::tmc_alu_t r;
        logic [8:0]        w;
        w = '0;
        case (f)
            tmc_pkg::F_LOAD:  w = {cin, b};
            tmc_pkg::F_AND:   w = {1'b0, a & b};
            tmc_pkg::F_OR:    w = {1'b0, a | b};
            tmc_pkg::F_XOR:   w = {1'b0, a ^ b};
            tmc_pkg::F_ADD:   w = {1'b0, a} + {1'b0, b};
            tmc_pkg::F_ADDCY: w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            tmc_pkg::F_SUB:   w = {1'b0, a} - {1'b0, b};
            tmc_pkg::F_SUBCY: w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            default:          w = '0;
        endcase
        r.y = w[7:0];
        r.c = w[8];
        r.z = (w[7:0] == 8'h00);
        return r;
    endfunction

    function automatic tmc_pkg::tmc_alu_t shf(input logic [3:0] code,
        input logic [7:0] a, input logic cin);
        tmc_pkg::tmc_alu_t r;
        logic              left;
        logic [3:0]        k;
        logic              fill;
        left = (code >= tmc_pkg::SH_LEFT);
        k    = left ? code - tmc_pkg::SH_LEFT : code;
        case (k)
            tmc_pkg::SH_ZERO: fill = 1'b0;
            tmc_pkg::SH_ONE:  fill = 1'b1;
            tmc_pkg::SH_EXT:  fill = left ? a[0] : a[7];
            tmc_pkg::SH_CY:   fill = cin;
            tmc_pkg::SH_ROT:  fill = left ? a[7] : a[0];
            default:          fill = 1'b0;
        endcase
        r.y = left ? {a[6:0], fill} : {fill, a[7:1]};
        r.c = left ? a[7] : a[0];
        r.z = (r.y == 8'h00);
        return r;
    endfunction

    function automatic logic [3:0] sp_up(input logic [3:0] p);
        return (p == SP_LAST) ? 4'h0 : p + 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode; instruction word is valid only in phase 1

    assign op  = i_instr[15:12];
    assign sx  = i_instr[11:8];
    assign sy  = i_instr[7:4];
    assign kk  = i_instr[7:0];
    assign irq = s_ff.ph & s_ff.ie & i_interrupt;
    assign sp_dn = (s_ff.sp == 4'h0) ? SP_LAST : s_ff.sp - 4'h1;

    tmc_regbank u_rb
    (
        .i_mclk (i_mclk),
        .i_wr   (rb_wr),
        .i_ra   (sx),
        .i_rb   (sy),
        .o_qa   (rx),
        .o_qb   (ry)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        nxt_s    = s_ff;
        rb_wr    = '0;
        res      = '0;
        nxt_s.rd = 1'b0;
        nxt_s.wr = 1'b0;
        nxt_s.ph = ~s_ff.ph;
        if (!s_ff.ph)
        begin
            // input lands in phase 0, clear of phase-1 alu writes
            if (s_ff.rd)
            begin
                rb_wr.en   = 1'b1;
                rb_wr.idx  = s_ff.rdst;
                rb_wr.data = i_in_port;
            end
        end
        else if (irq)
        begin
            // the current instruction is abandoned and rerun on return
            nxt_s.stk[s_ff.sp] = s_ff.pc - 8'h01;
            nxt_s.sp = sp_up(s_ff.sp);
            nxt_s.pc = tmc_pkg::IRQ_VEC;
            nxt_s.sz = s_ff.z;
            nxt_s.sc = s_ff.c;
            nxt_s.ie = 1'b0;
        end
        else
        begin
            nxt_s.pc = s_ff.pc + 8'h01;
            case (op)
                tmc_pkg::OP_ALUR, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
                begin
                    if (op == tmc_pkg::OP_ALUR)
                        res = alu(i_instr[2:0], rx, ry, s_ff.c);
                    else
                        res = alu(op[2:0], rx, kk, s_ff.c);
                    rb_wr = '{en: 1'b1, idx: sx, data: res.y};
                    if (!(op == tmc_pkg::OP_ALUR ? i_instr[2:0] == tmc_pkg::F_LOAD
                                                 : op[2:0] == tmc_pkg::F_LOAD))
                    begin
                        nxt_s.z = res.z;
                        nxt_s.c = res.c;
                    end
                end
                tmc_pkg::OP_MISC:
                begin
                    case (i_instr[7:4])
                        tmc_pkg::M_SHIFT:
                        begin
                            res     = shf(i_instr[3:0], rx, s_ff.c);
                            rb_wr   = '{en: 1'b1, idx: sx, data: res.y};
                            nxt_s.z = res.z;
                            nxt_s.c = res.c;
                        end
                        tmc_pkg::M_RET:
                        begin
                            if (cond_ok(i_instr[3:0], s_ff.z, s_ff.c))
                            begin
                                nxt_s.pc = s_ff.stk[sp_dn] + 8'h01;
                                nxt_s.sp = sp_dn;
                            end
                        end
                        tmc_pkg::M_RETI:
                        begin
                            nxt_s.pc = s_ff.stk[sp_dn] + 8'h01;
                            nxt_s.sp = sp_dn;
                            nxt_s.z  = s_ff.sz;
                            nxt_s.c  = s_ff.sc;
                            nxt_s.ie = i_instr[0];
                        end
                        tmc_pkg::M_IE:
                        begin
                            nxt_s.ie = i_instr[0];
                        end
                        default:
                        begin
                            nxt_s.pc = s_ff.pc + 8'h01;
                        end
                    endcase
                end
                tmc_pkg::OP_IN_K, tmc_pkg::OP_IN_R:
                begin
                    nxt_s.psel = (op == tmc_pkg::OP_IN_K) ? kk : ry;
                    nxt_s.rd   = 1'b1;
                    nxt_s.rdst = sx;
                end
                tmc_pkg::OP_OUT_K, tmc_pkg::OP_OUT_R:
                begin
                    nxt_s.psel = (op == tmc_pkg::OP_OUT_K) ? kk : ry;
                    nxt_s.pout = rx;
                    nxt_s.wr   = 1'b1;
                end
                tmc_pkg::OP_JUMP:
                begin
                    if (cond_ok(sx, s_ff.z, s_ff.c))
                        nxt_s.pc = kk;
                end
                tmc_pkg::OP_CALL:
                begin
                    if (cond_ok(sx, s_ff.z, s_ff.c))
                    begin
                        nxt_s.stk[s_ff.sp] = s_ff.pc;
                        nxt_s.sp = sp_up(s_ff.sp);
                        nxt_s.pc = kk;
                    end
                end
                default:
                begin
                    nxt_s.pc = s_ff.pc + 8'h01;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            s_ff <= tmc_pkg::ST_RESET;
        else
            s_ff <= nxt_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; the program memory sees pc through all of phase 0

    assign o_addr  = s_ff.pc;
    assign o_io.psel = s_ff.psel;
    assign o_io.data = s_ff.pout;
    assign o_io.rd   = s_ff.rd;
    assign o_io.wr   = s_ff.wr;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_phase;
        @(posedge i_mclk) disable iff (!i_resetn)
        s_ff.ph |=> !s_ff.ph ##1 s_ff.ph;
    endproperty
    a_phase: assert property (p_phase) else $error("phase did not alternate");

    property p_pc_hold;
        @(posedge i_mclk) disable iff (!i_resetn)
        !s_ff.ph |=> $stable(s_ff.pc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved mid instruction");

    property p_irq;
        @(posedge i_mclk) disable iff (!i_resetn)
        irq |=> s_ff.pc == tmc_pkg::IRQ_VEC && !s_ff.ie && s_ff.sz == $past(s_ff.z)
                && s_ff.sc == $past(s_ff.c);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt entry wrong");

    property p_jump;
        @(posedge i_mclk) disable iff (!i_resetn)
        s_ff.ph && !irq && op == tmc_pkg::OP_JUMP && cond_ok(sx, s_ff.z, s_ff.c)
        |=> s_ff.pc == $past(kk);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_seq;
        @(posedge i_mclk) disable iff (!i_resetn)
        s_ff.ph && !irq && op[3] == 1'b0 |=> s_ff.pc == $past(s_ff.pc) + 8'h01;
    endproperty
    a_seq: assert property (p_seq) else $error("pc did not step");

    property p_call_sp;
        @(posedge i_mclk) disable iff (!i_resetn)
        s_ff.ph && !irq && op == tmc_pkg::OP_CALL && cond_ok(sx, s_ff.z, s_ff.c)
        |=> s_ff.sp == sp_up($past(s_ff.sp)) && s_ff.stk[$past(s_ff.sp)] == $past(s_ff.pc);
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("call push wrong");

    property p_wr_pulse;
        @(posedge i_mclk) disable iff (!i_resetn)
        o_io.wr |-> ##1 !o_io.wr && $stable(o_io.psel) && $stable(o_io.data);
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");

    property p_rd_pulse;
        @(posedge i_mclk) disable iff (!i_resetn)
        o_io.rd |-> !s_ff.ph ##1 (!o_io.rd && $stable(o_io.psel));
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse wrong");

endmodule

//--- verilog/tmc_pkg.sv
/*
 package of the 8-bit core: sizes, instruction coding, carrier structs
 and the reset image of the core state. assumes a single 100 MHz clock.
*/
package tmc_pkg;

    localparam int unsigned DW      = 8;
    localparam int unsigned IW      = 16;
    localparam int unsigned NREG    = 16;
    localparam int unsigned STK_MAX = 15;

    localparam logic [7:0] RST_PC  = 8'h00;
    localparam logic [7:0] IRQ_VEC = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // major opcode, instr[15:12]; 0..7 are alu ops with a constant
    localparam logic [3:0] OP_ALUR  = 4'h8;
    localparam logic [3:0] OP_MISC  = 4'h9;
    localparam logic [3:0] OP_IN_K  = 4'ha;
    localparam logic [3:0] OP_IN_R  = 4'hb;
    localparam logic [3:0] OP_OUT_K = 4'hc;
    localparam logic [3:0] OP_OUT_R = 4'hd;
    localparam logic [3:0] OP_JUMP  = 4'he;
    localparam logic [3:0] OP_CALL  = 4'hf;

    // alu function
    localparam logic [2:0] F_LOAD  = 3'h0;
    localparam logic [2:0] F_AND   = 3'h1;
    localparam logic [2:0] F_OR    = 3'h2;
    localparam logic [2:0] F_XOR   = 3'h3;
    localparam logic [2:0] F_ADD   = 3'h4;
    localparam logic [2:0] F_ADDCY = 3'h5;
    localparam logic [2:0] F_SUB   = 3'h6;
    localparam logic [2:0] F_SUBCY = 3'h7;

    // misc group, instr[7:4]
    localparam logic [3:0] M_SHIFT = 4'h0;
    localparam logic [3:0] M_RET   = 4'h1;
    localparam logic [3:0] M_RETI  = 4'h2;
    localparam logic [3:0] M_IE    = 4'h3;

    // shift code, instr[3:0]; codes from SH_LEFT up shift left
    localparam logic [3:0] SH_ZERO = 4'h0;
    localparam logic [3:0] SH_ONE  = 4'h1;
    localparam logic [3:0] SH_EXT  = 4'h2;
    localparam logic [3:0] SH_CY   = 4'h3;
    localparam logic [3:0] SH_ROT  = 4'h4;
    localparam logic [3:0] SH_LEFT = 4'h5;

    // condition, instr[11:8] of jump/call, instr[3:0] of return
    localparam logic [3:0] C_ALW = 4'h0;
    localparam logic [3:0] C_Z   = 4'h4;
    localparam logic [3:0] C_NZ  = 4'h5;
    localparam logic [3:0] C_C   = 4'h6;
    localparam logic [3:0] C_NC  = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] psel;
        logic [7:0] data;
        logic       rd;
        logic       wr;
    } tmc_io_t;

    typedef struct packed {
        logic       en;
        logic [3:0] idx;
        logic [7:0] data;
    } tmc_wr_t;

    typedef struct packed {
        logic       c;
        logic       z;
        logic [7:0] y;
    } tmc_alu_t;

    typedef struct packed {
        logic [NREG-1:0][7:0] r;
    } tmc_rb_t;

    typedef struct packed {
        logic [7:0]              pc;
        logic                    ph;
        logic                    z;
        logic                    c;
        logic                    ie;
        logic                    sz;
        logic                    sc;
        logic [3:0]              sp;
        logic [STK_MAX-1:0][7:0] stk;
        logic [7:0]              psel;
        logic [7:0]              pout;
        logic                    rd;
        logic                    wr;
        logic [3:0]              rdst;
    } tmc_state_t;

    localparam tmc_state_t ST_RESET = '0;

endpackage

//--- verilog/tmc_regbank.sv
/*
 general register bank: sixteen 8-bit registers, two read ports and
 one write port. assumes the core drives the write port; the bank has
 no reset so a reset of the core leaves its contents alone.
*/
`timescale 1ns/1ps
module tmc_regbank
(
    input  wire logic             i_mclk,
    input  tmc_pkg::tmc_wr_t      i_wr,
    input  wire logic [3:0]       i_ra,
    input  wire logic [3:0]       i_rb,
    output logic [7:0]            o_qa,
    output logic [7:0]            o_qb
);

    tmc_pkg::tmc_rb_t rb_ff;
    tmc_pkg::tmc_rb_t nxt_rb;

    ////////////////////////////////////////////////////////////////////////
    // no register is special: any index may be read or written
    always_comb
    begin
        nxt_rb = rb_ff;
        if (i_wr.en)
        begin
            nxt_rb.r[i_wr.idx] = i_wr.data;
        end
    end

    // no reset on purpose: contents survive a core reset
    always_ff @(posedge i_mclk)
    begin
        rb_ff <= nxt_rb;
    end

    assign o_qa = rb_ff.r[i_ra];
    assign o_qb = rb_ff.r[i_rb];

    property p_wr_lands;
        @(posedge i_mclk) i_wr.en |=> rb_ff.r[$past(i_wr.idx)] == $past(i_wr.data);
    endproperty
    a_wr_lands: assert property (p_wr_lands) else $error("register write lost");

endmodule
